// File: a429_rx_support_pkg.sv
package a429_rx_support_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [15:0] ADDR_LEVEL_FLAGS_LOW = 16'h800d;
   localparam logic [15:0] ADDR_LEVEL_FLAGS_HIGH = 16'h800e;
   localparam logic [15:0] ADDR_LOOPBACK_ROUTING = 16'h8049;
   localparam logic [15:0] ADDR_IRQ_ENABLE_LOW = 16'h804d;
   localparam logic [15:0] ADDR_IRQ_ENABLE_HIGH = 16'h804e;
   localparam logic [15:0] ADDR_THRESHOLD_BASE = 16'h8050;
   localparam int REG_W = 8;
   localparam logic [REG_W-1:0] RESET_BYTE = 8'h00;
   localparam logic [REG_W-1:0] READ_UNMAPPED = 8'h00;

   // ****************************************
   // channel geometry
   // ****************************************
   localparam int RX_CHANNELS = 16;
   localparam int TX_CHANNELS = 8;
   localparam int FIFO_DEPTH = 64;
   localparam int THRESH_W = 7;
   localparam int COUNT_W = 7;
   localparam logic [THRESH_W-1:0] THRESH_RESET = 7'h00;

   // ****************************************
   // serial word layout
   // ****************************************
   localparam int WORD_W = 32;
   localparam int LABEL_W = 8;
   localparam int LABEL_LSB = 0;
   localparam int BYTE1_LSB = 8;
   localparam int BYTE2_LSB = 16;
   localparam int BYTE3_LSB = 24;
   localparam int PARITY_POS = 31;

endpackage

// File: label_order.sv
`timescale 1ns/1ns
// label byte order: word index k holds serial bit k+1
module label_order
   import a429_rx_support_pkg::*;
(
   input wire logic [a429_rx_support_pkg::WORD_W-1:0] word_in,
   input wire logic reverse,
   output logic [a429_rx_support_pkg::WORD_W-1:0] word_out
);
   logic [LABEL_W-1:0] label_flipped;

   genvar i;
   generate
      for (i = 0; i < LABEL_W; i = i + 1) begin : g_flip
         assign label_flipped[i] = word_in[LABEL_LSB + LABEL_W - 1 - i];
      end
   endgenerate

   // data field and parity keep their place, only the label turns
   assign word_out = {word_in[WORD_W-1:LABEL_W],
                      reverse ? label_flipped : word_in[LABEL_W-1:0]};
endmodule

// File: rx_fifo_flags_loopback_order.sv
`timescale 1ns/1ns
module rx_fifo_flags_loopback_order
   import a429_rx_support_pkg::*;
#(
   parameter int RX_CH = a429_rx_support_pkg::RX_CHANNELS,
   parameter int TX_CH = a429_rx_support_pkg::TX_CHANNELS,
   parameter int DEPTH = a429_rx_support_pkg::FIFO_DEPTH
)
(
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [15:0] reg_addr,
   input wire logic [a429_rx_support_pkg::REG_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [a429_rx_support_pkg::REG_W-1:0] reg_rdata,
   // global controls
   input wire logic transmit_pin_mask,
   input wire logic label_reverse,
   // fifo fill levels, channel c at [c*COUNT_W +: COUNT_W]
   input wire logic [RX_CH*a429_rx_support_pkg::COUNT_W-1:0] fifo_count,
   output logic fifo_clear,
   output logic [RX_CH-1:0] fifo_level_flags,
   output logic [RX_CH-1:0] fifo_irq_pending,
   output logic fifo_irq,
   // serial lines
   input wire logic [RX_CH-1:0] rx_pin,
   input wire logic [TX_CH-1:0] tx_line,
   output logic [RX_CH-1:0] rx_line,
   output logic [TX_CH-1:0] tx_pin,
   // word ordering
   input wire logic [a429_rx_support_pkg::WORD_W-1:0] rx_word,
   input wire logic rx_word_valid,
   output logic [a429_rx_support_pkg::LABEL_W-1:0] match_label,
   output logic [a429_rx_support_pkg::WORD_W-1:0] store_bytes,
   output logic store_valid,
   input wire logic [a429_rx_support_pkg::WORD_W-1:0] tx_word,
   output logic [a429_rx_support_pkg::WORD_W-1:0] tx_word_ordered
);
   import a429_rx_support_pkg::*;

   // ****************************************
   // elaboration checks
   // ****************************************
   // refused while elaborating, so a bad build never reaches simulation
   generate
      if (RX_CH != 2 * TX_CH || TX_CH < 1 || TX_CH > REG_W) begin : g_bad_channels
         $error("channel counts do not fit the byte registers");
      end
      if (DEPTH < 1 || DEPTH >= (1 << COUNT_W) || DEPTH > (1 << THRESH_W) - 1) begin : g_bad_depth
         $error("fifo depth does not fit count width");
      end
   endgenerate

   // threshold register index, wide enough for every receive channel
   localparam int IDX_W = (RX_CH > 2) ? $clog2(RX_CH) : 1;

   // ****************************************
   // register storage
   // ****************************************
   logic [THRESH_W-1:0] threshold [RX_CH];
   logic [RX_CH-1:0] fifo_irq_enables;
   logic [TX_CH-1:0] loopback_routing;
   logic [RX_CH-1:0] level_now;

   // ****************************************
   // address decode
   // ****************************************
   wire hit_flags_low = reg_addr == ADDR_LEVEL_FLAGS_LOW;
   wire hit_flags_high = reg_addr == ADDR_LEVEL_FLAGS_HIGH;
   wire hit_loop = reg_addr == ADDR_LOOPBACK_ROUTING;
   wire hit_ie_low = reg_addr == ADDR_IRQ_ENABLE_LOW;
   wire hit_ie_high = reg_addr == ADDR_IRQ_ENABLE_HIGH;
   wire [15:0] thr_offset = reg_addr - ADDR_THRESHOLD_BASE;
   wire hit_thr = reg_addr >= ADDR_THRESHOLD_BASE && thr_offset < 16'(RX_CH);
   wire [IDX_W-1:0] thr_index = thr_offset[IDX_W-1:0];

   wire [REG_W-1:0] ie_low_byte = REG_W'(fifo_irq_enables[RX_CH/2-1:0]);
   wire [REG_W-1:0] ie_high_byte = REG_W'(fifo_irq_enables[RX_CH-1:RX_CH/2]);
   wire [REG_W-1:0] flags_low_byte = REG_W'(fifo_level_flags[RX_CH/2-1:0]);
   wire [REG_W-1:0] flags_high_byte = REG_W'(fifo_level_flags[RX_CH-1:RX_CH/2]);
   wire [REG_W-1:0] thr_byte = REG_W'(threshold[thr_index]);

   wire [REG_W-1:0] next_rdata =
      hit_flags_low ? flags_low_byte :
      hit_flags_high ? flags_high_byte :
      hit_loop ? REG_W'(loopback_routing) :
      hit_ie_low ? ie_low_byte :
      hit_ie_high ? ie_high_byte :
      hit_thr ? thr_byte : READ_UNMAPPED;

   // ****************************************
   // register writes
   // ****************************************
   // level flag registers have no write path: read only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         loopback_routing <= '0;
      end else if (reg_wr && hit_loop) begin
         loopback_routing <= reg_wdata[TX_CH-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         fifo_irq_enables <= '0;
      end else if (reg_wr && hit_ie_low) begin
         fifo_irq_enables[RX_CH/2-1:0] <= reg_wdata[RX_CH/2-1:0];
      end else if (reg_wr && hit_ie_high) begin
         fifo_irq_enables[RX_CH-1:RX_CH/2] <= reg_wdata[RX_CH/2-1:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= RESET_BYTE;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end
   end

   // ****************************************
   // per-channel threshold and level flag
   // ****************************************
   genvar c;
   generate
      for (c = 0; c < RX_CH; c = c + 1) begin : g_chan
         wire [COUNT_W-1:0] count = fifo_count[c*COUNT_W +: COUNT_W];
         wire [COUNT_W-1:0] thr = COUNT_W'(threshold[c]);
         // thresholds past the depth can never be exceeded, so they mean full
         wire beyond = thr >= COUNT_W'(DEPTH);
         // a full fifo sits at DEPTH, oldest word dropped upstream
         wire is_full = count == COUNT_W'(DEPTH);
         // zero threshold falls out of count > 0, i.e. not empty
         assign level_now[c] = beyond ? is_full : count > thr;

         always_ff @(posedge core_clk) begin
            if (rst) begin
               threshold[c] <= THRESH_RESET;
            end else if (reg_wr && hit_thr && thr_index == IDX_W'(c)) begin
               threshold[c] <= reg_wdata[THRESH_W-1:0];
            end
         end
      end
   endgenerate

   // ****************************************
   // flags and pending interrupts
   // ****************************************
   // registered each cycle: a new threshold shows one edge after its write
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fifo_level_flags <= '0;
         fifo_irq_pending <= '0;
         fifo_irq <= 1'b0;
      end else begin
         fifo_level_flags <= level_now;
         fifo_irq_pending <= level_now & fifo_irq_enables;
         fifo_irq <= |(level_now & fifo_irq_enables);
      end
   end

   // storage logic outside empties its fifos while this is high
   always_ff @(posedge core_clk) begin
      fifo_clear <= rst;
   end

   // ****************************************
   // loop-back routing and transmit mask
   // ****************************************
   logic [RX_CH-1:0] next_rx_line;
   generate
      for (c = 0; c < RX_CH; c = c + 1) begin : g_route
         // external pin is not even looked at while looped
         assign next_rx_line[c] = loopback_routing[c/2] ? tx_line[c/2] : rx_pin[c];
      end
   endgenerate

   wire [TX_CH-1:0] next_tx_pin = transmit_pin_mask ? '0 : tx_line;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_line <= '0;
         tx_pin <= '0;
      end else begin
         rx_line <= next_rx_line;
         tx_pin <= next_tx_pin;
      end
   end

   // ****************************************
   // word ordering
   // ****************************************
   logic [WORD_W-1:0] rx_ordered;
   logic [WORD_W-1:0] tx_ordered;

   label_order u_rx_order (
      .word_in(rx_word),
      .reverse(label_reverse),
      .word_out(rx_ordered)
   );

   label_order u_tx_order (
      .word_in(tx_word),
      .reverse(label_reverse),
      .word_out(tx_ordered)
   );

   // byte 0 label, byte 1 bits 9-16, byte 2 bits 17-24, byte 3 bits 25-32
   wire [WORD_W-1:0] next_store = {rx_ordered[BYTE3_LSB +: LABEL_W],
                                   rx_ordered[BYTE2_LSB +: LABEL_W],
                                   rx_ordered[BYTE1_LSB +: LABEL_W],
                                   rx_ordered[LABEL_LSB +: LABEL_W]};

   always_ff @(posedge core_clk) begin
      if (rst) begin
         store_bytes <= '0;
         match_label <= '0;
         store_valid <= 1'b0;
         tx_word_ordered <= '0;
      end else begin
         store_valid <= rx_word_valid;
         tx_word_ordered <= tx_ordered;
         if (rx_word_valid) begin
            store_bytes <= next_store;
            match_label <= rx_ordered[LABEL_LSB +: LABEL_W];
         end
      end
   end
endmodule

// File: rx_support_props.sv
`timescale 1ns/1ns
// ****************************************
// word, flag and interrupt checks
// ****************************************
module rx_support_props
   import a429_rx_support_pkg::*;
#(parameter int RX_CH = 16)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic label_reverse,
   input wire logic [RX_CH*a429_rx_support_pkg::COUNT_W-1:0] fifo_count,
   input wire logic [RX_CH-1:0] fifo_level_flags,
   input wire logic [RX_CH-1:0] fifo_irq_pending,
   input wire logic fifo_irq,
   input wire logic [31:0] rx_word,
   input wire logic rx_word_valid,
   input wire logic [7:0] match_label,
   input wire logic [31:0] store_bytes,
   input wire logic store_valid
);
   wire logic [7:0] rx_flip = {rx_word[0], rx_word[1], rx_word[2], rx_word[3],
      rx_word[4], rx_word[5], rx_word[6], rx_word[7]};
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   store_pulse_a: assert property (rx_word_valid |=> store_valid)
      else $error("store pulse missing");
   no_store_a: assert property (!rx_word_valid |=> !store_valid)
      else $error("store pulse without word");
   plain_order_a: assert property (rx_word_valid && !label_reverse |=>
      store_bytes == $past(rx_word) && match_label == $past(rx_word[7:0]))
      else $error("stored word not in order");
   flip_order_a: assert property (rx_word_valid && label_reverse |=>
      match_label == $past(rx_flip) && store_bytes == {$past(rx_word[31:8]), $past(rx_flip)})
      else $error("reversed label wrong");
   pend_gated_a: assert property ((fifo_irq_pending & ~fifo_level_flags) == '0)
      else $error("pending bit without flag");
   irq_merge_a: assert property (fifo_irq == |fifo_irq_pending)
      else $error("interrupt not merge of pending");
   empty_flag_a: assert property (fifo_count[6:0] == 7'h00 |=> !fifo_level_flags[0])
      else $error("flag on empty fifo");
   full_flag_a: assert property (fifo_count[6:0] == 7'h40 |=> fifo_level_flags[0])
      else $error("flag missing on full fifo");
endmodule
bind rx_fifo_flags_loopback_order rx_support_props #(.RX_CH(RX_CH)) u_rx_support_props (
   .core_clk(core_clk), .rst(rst), .label_reverse(label_reverse), .fifo_count(fifo_count),
   .fifo_level_flags(fifo_level_flags), .fifo_irq_pending(fifo_irq_pending),
   .fifo_irq(fifo_irq), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
   .match_label(match_label), .store_bytes(store_bytes), .store_valid(store_valid));

// File: host_model.sv
`timescale 1ns/1ns
// ****************************************
// host register master
// ****************************************
module host_model
   import a429_rx_support_pkg::*;
(
   input wire logic core_clk,
   input wire logic [a429_rx_support_pkg::REG_W-1:0] reg_rdata,
   output logic [15:0] reg_addr = 16'h0000,
   output logic [a429_rx_support_pkg::REG_W-1:0] reg_wdata = 8'h00,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0
);
   // strobe stands one edge; address inverted after so stale values never match
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule

// File: tb.sv
`timescale 1ns/1ns
// ****************************************
// bench
// ****************************************
module tb;
   import a429_rx_support_pkg::*;
   logic core_clk = 0, rst = 1, reg_wr, reg_rd, fifo_clear, fifo_irq, store_valid;
   logic transmit_pin_mask = 0, label_reverse = 0, rx_word_valid = 0;
   logic [15:0] reg_addr, fifo_level_flags, fifo_irq_pending, rx_line, rx_pin = '0;
   logic [7:0] reg_wdata, reg_rdata, tx_pin, match_label, tx_line = '0;
   logic [111:0] fifo_count = '0;
   logic [31:0] store_bytes, tx_word_ordered, rx_word = '0, tx_word = '0;
   int miscompares = 0, n_checks = 0, cycles = 0;
   rx_fifo_flags_loopback_order u_rx_fifo_flags_loopback_order (.core_clk(core_clk),
      .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .transmit_pin_mask(transmit_pin_mask), .fifo_count(fifo_count),
      .label_reverse(label_reverse), .fifo_clear(fifo_clear), .fifo_irq(fifo_irq),
      .fifo_level_flags(fifo_level_flags), .fifo_irq_pending(fifo_irq_pending),
      .rx_pin(rx_pin), .tx_line(tx_line), .rx_line(rx_line), .tx_pin(tx_pin),
      .rx_word(rx_word), .rx_word_valid(rx_word_valid), .match_label(match_label),
      .store_bytes(store_bytes), .store_valid(store_valid), .tx_word(tx_word),
      .tx_word_ordered(tx_word_ordered));
   host_model u_host_model (.core_clk(core_clk), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
   initial begin
      forever #50 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_host_model.rd(a, d);
      chk("register", e, d);
   endtask
   // registered outputs need one edge to land, one more for margin
   task automatic settle;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic t_reset;
      chk("fifo clear", 0, fifo_clear);
      rdchk(16'h800d, 8'h00);
      rdchk(16'h800e, 8'h00);
      rdchk(16'h8049, 8'h00);
      rdchk(16'h804d, 8'h00);
      rdchk(16'h804e, 8'h00);
      rdchk(16'h805f, 8'h00);
      rdchk(16'h8000, READ_UNMAPPED);
      $display("reset test done");
   endtask
   task automatic t_thresh;
      int thr[8] = '{0, 0, 1, 1, 16, 16, 127, 127};
      int cnt[8] = '{0, 1, 1, 2, 16, 17, 63, 64};
      for (int i = 0; i < 8; i++) begin
         u_host_model.wr(16'h8050, 8'(thr[i]));
         @(posedge core_clk) fifo_count[6:0] <= 7'(cnt[i]);
         settle();
         chk("flag 0", i % 2, fifo_level_flags[0]);
      end
      u_host_model.wr(16'h800d, 8'hff);
      rdchk(16'h800d, 8'h01);
      u_host_model.wr(16'h805f, 8'h03);
      @(posedge core_clk) fifo_count[111:105] <= 7'h04;
      settle();
      rdchk(16'h800e, 8'h80);
      rdchk(16'h8050, 8'h7f);
      $display("threshold test done");
   endtask
   task automatic t_irq;
      u_host_model.wr(16'h804d, 8'h01);
      settle();
      chk("pending", 32'h0001, fifo_irq_pending);
      chk("irq", 1, fifo_irq);
      u_host_model.wr(16'h804e, 8'h80);
      rdchk(16'h804e, 8'h80);
      chk("pending", 32'h8001, fifo_irq_pending);
      $display("interrupt test done");
   endtask
   task automatic t_loop;
      for (int n = 0; n < 8; n++) begin
         u_host_model.wr(16'h8049, 8'h01 << n);
         @(posedge core_clk) tx_line <= 8'h01 << n;
         rx_pin <= ~(16'h0003 << 2 * n);
         settle();
         chk("rx line", 32'hffff, rx_line);
         @(posedge core_clk) tx_line <= 8'h00;
         settle();
         chk("rx line", 16'hffff & ~(16'h0003 << 2 * n), rx_line);
      end
      @(posedge core_clk) tx_line <= 8'h5a;
      settle();
      chk("tx pin", 8'h5a, tx_pin);
      @(posedge core_clk) transmit_pin_mask <= 1;
      settle();
      chk("tx pin", 0, tx_pin);
      $display("loop test done");
   endtask
   task automatic t_word;
      for (int r = 0; r < 2; r++) begin
         @(posedge core_clk) label_reverse <= r[0];
         rx_word <= 32'h12345601;
         rx_word_valid <= 1;
         tx_word <= 32'habcdef03;
         @(posedge core_clk) rx_word_valid <= 0;
         #1;
         chk("store valid", 1, store_valid);
         chk("stored", r ? 32'h12345680 : 32'h12345601, store_bytes);
         chk("label", r ? 8'h80 : 8'h01, match_label);
         chk("tx word", r ? 32'habcdefc0 : 32'habcdef03, tx_word_ordered);
      end
      $display("word test done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      @(posedge core_clk) #1;
      chk("fifo clear", 1, fifo_clear);
      @(posedge core_clk) rst <= 0;
      @(posedge core_clk) #1;
      t_reset();
      t_thresh();
      t_irq();
      t_loop();
      t_word();
      wrap_up();
   end
endmodule
